//--- logic/fps_device.sv
/*
 Device end: command sequencer for bank erase, multi-word, streaming and
 quad-page factory programs, with an internal array and status word.
 Assumes the host polls status between data writes.
*/
// Notes on behaviour
// - Quad pages are four words, A1:A0 vary.
// - Without high voltage, quad command ignored silently.
// - No other-bank reads or suspend while active.
// - Protected block aborts with error, unchanged.
// - Quad program starts with single 75h write.
// - After setup reads return status only.
// - Load phase takes exactly four writes.
// - First write latches start; same address advances page.
// - FFFFh outside start block enters exit.
// - Host checks idle flag low after first word.
// - Only first page word address is checked.
// - Engine programs and verifies without host; no reprogram. Code never verifies the fourth page word.
// - During program idle low, bank write high.
// - Next first word restarts load phase.
// - End shows idle high, bank low; read array.
// - Unprogrammable location flags status failure.
// - Bank erase is 80h then D0h.
// - Double word: 35h then two pairs.
// - Quad word: 56h then four pairs.
// - Stream: 30h, D0h, n data, FFFFh, verify pass, FFFFh exit.
// - Stream address stays or increments.
// - Host polls status between data writes.
// - Idle flag low while engine active.
module fps_device #(
   parameter int MEM_WORDS = 256,
   parameter int PROT_BLOCK = 1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Flash bus.
   fps_if.dev bus,
   // Device observation.
   output logic busy
);
   if (MEM_WORDS < 16 || (MEM_WORDS & (MEM_WORDS - 1)) != 0) begin : g_bad
      $error("MEM_WORDS must be a power of two of at least 16");
   end
   localparam int MW = $clog2(MEM_WORDS);
   typedef enum logic [3:0] {
      ST_ARRAY, ST_ERASE_CFM, ST_MULTI, ST_STREAM_CFM, ST_STREAM,
      ST_QLOAD, ST_ENGINE
   } fpsd_state_e;
   typedef struct packed {
      fpsd_state_e st;
      logic statusMode;
      logic [15:0] status;
      logic [21:0] start;
      logic [21:0] ptr;
      logic [2:0] cnt;
      logic [2:0] need;
      logic [1:0] phaseQ;
      logic [15:0] buf0;
      logic [15:0] buf1;
      logic [15:0] buf2;
      logic [15:0] buf3;
      logic [7:0] timer;
      logic firstPage;
      logic streaming;
      logic [15:0] rdata;
      logic rdValid;
      logic busy;
   } fpsd_s;
   fpsd_s cur_ff, nxt_cur;
   logic [15:0] mem [MEM_WORDS];
   logic memWe;
   logic [MW-1:0] memAddr;
   logic [15:0] memData;
   logic sameBlock;
   logic protect;
   logic protectPage;
   logic [15:0] pageWord;
   logic [15:0] prevWord;

   assign sameBlock = bus.addr[21:fps_pkg::BLOCK_LSB]
      == cur_ff.start[21:fps_pkg::BLOCK_LSB];
   assign protect = int'(bus.addr[21:fps_pkg::BLOCK_LSB]) == PROT_BLOCK;
   // The page's own block decides, not the free address of a later word.
   assign protectPage = int'(cur_ff.ptr[21:fps_pkg::BLOCK_LSB])
      == PROT_BLOCK;
   assign busy = cur_ff.busy;
   assign bus.rdata = cur_ff.rdata;
   assign bus.rdValid = cur_ff.rdValid;

   always_comb begin
      unique case (cur_ff.cnt[1:0])
         2'd0: pageWord = cur_ff.buf0;
         2'd1: pageWord = cur_ff.buf1;
         2'd2: pageWord = cur_ff.buf2;
         default: pageWord = cur_ff.buf3;
      endcase
   end

   always_comb begin
      unique case (cur_ff.cnt[1:0])
         2'd1: prevWord = cur_ff.buf0;
         2'd2: prevWord = cur_ff.buf1;
         default: prevWord = cur_ff.buf2;
      endcase
   end

   always_comb begin
      nxt_cur = cur_ff;
      memWe = 1'b0;
      memAddr = cur_ff.ptr[MW-1:0];
      memData = 16'h0000;
      nxt_cur.rdValid = 1'b0;
      if (bus.rdStb) begin
         nxt_cur.rdValid = 1'b1;
         // Every read gives status while a program flow owns the array.
         if (cur_ff.statusMode) begin
            nxt_cur.rdata = cur_ff.status;
         end else begin
            nxt_cur.rdata = mem[bus.addr[MW-1:0]];
         end
      end
      unique case (cur_ff.st)
         ST_ARRAY: if (bus.wrStb) begin
            nxt_cur.start = bus.addr;
            nxt_cur.ptr = bus.addr;
            nxt_cur.cnt = 3'd0;
            if (bus.wdata == fps_pkg::CMD_QUAD_FACTORY) begin
               if (bus.programSupplyPin) begin
                  nxt_cur.st = ST_QLOAD;
                  nxt_cur.statusMode = 1'b1;
                  nxt_cur.firstPage = 1'b1;
                  nxt_cur.phaseQ = 2'd0;
               end
            end else if (bus.wdata == fps_pkg::CMD_BANK_ERASE) begin
               nxt_cur.st = ST_ERASE_CFM;
            end else if (bus.wdata == fps_pkg::CMD_DOUBLE_WORD) begin
               nxt_cur.st = ST_MULTI;
               nxt_cur.need = 3'd2;
               nxt_cur.statusMode = 1'b1;
            end else if (bus.wdata == fps_pkg::CMD_QUAD_WORD) begin
               nxt_cur.st = ST_MULTI;
               nxt_cur.need = 3'd4;
               nxt_cur.statusMode = 1'b1;
            end else if (bus.wdata == fps_pkg::CMD_STREAM) begin
               nxt_cur.st = ST_STREAM_CFM;
            end
         end
         ST_ERASE_CFM: if (bus.wrStb) begin
            nxt_cur.st = ST_ARRAY;
            if (bus.wdata == fps_pkg::CMD_CONFIRM) begin
               nxt_cur.statusMode = 1'b1;
               if (protect) begin
                  nxt_cur.status[fps_pkg::STAT_PROT_ERR_BIT] = 1'b1;
               end else begin
                  nxt_cur.st = ST_ENGINE;
                  nxt_cur.streaming = 1'b0;
                  nxt_cur.cnt = 3'd4;
                  nxt_cur.timer = 8'(fps_pkg::PROG_CYCLES);
                  nxt_cur.status[fps_pkg::STAT_IDLE_BIT] = 1'b0;
                  nxt_cur.status[fps_pkg::STAT_BANK_BIT] = 1'b1;
               end
            end
         end
         ST_MULTI: if (bus.wrStb) begin
            // Multi-word pairs write straight through, in order.
            memWe = !protect;
            memAddr = bus.addr[MW-1:0];
            memData = bus.wdata;
            if (protect) begin
               nxt_cur.status[fps_pkg::STAT_PROT_ERR_BIT] = 1'b1;
            end
            nxt_cur.cnt = cur_ff.cnt + 3'd1;
            if (cur_ff.cnt + 3'd1 == cur_ff.need) begin
               nxt_cur.st = ST_ARRAY;
            end
         end
         ST_STREAM_CFM: if (bus.wrStb) begin
            nxt_cur.st = ST_ARRAY;
            if (bus.wdata == fps_pkg::CMD_CONFIRM) begin
               nxt_cur.statusMode = 1'b1;
               nxt_cur.firstPage = 1'b1;
               nxt_cur.phaseQ = 2'd0;
               if (protect) begin
                  nxt_cur.status[fps_pkg::STAT_PROT_ERR_BIT] = 1'b1;
               end else begin
                  nxt_cur.st = ST_STREAM;
                  nxt_cur.status[fps_pkg::STAT_IDLE_BIT] = 1'b0;
               end
            end
         end
         ST_STREAM: if (bus.wrStb) begin
            if (!cur_ff.firstPage && !sameBlock
                  && bus.wdata == fps_pkg::DATA_EXIT) begin
               // Second terminator closes verify and hands back.
               if (cur_ff.phaseQ == 2'd1) begin
                  nxt_cur.st = ST_ARRAY;
                  nxt_cur.status[fps_pkg::STAT_IDLE_BIT] = 1'b1;
               end
               nxt_cur.phaseQ = 2'd1;
               nxt_cur.firstPage = 1'b1;
            end else if (cur_ff.firstPage || sameBlock) begin
               if (cur_ff.firstPage) begin
                  nxt_cur.start = bus.addr;
                  nxt_cur.ptr = bus.addr;
               end else if (bus.addr == cur_ff.start) begin
                  nxt_cur.ptr = cur_ff.ptr + 22'd1;
               end else begin
                  nxt_cur.ptr = bus.addr;
               end
               nxt_cur.firstPage = 1'b0;
               memAddr = nxt_cur.ptr[MW-1:0];
               memData = bus.wdata;
               memWe = (cur_ff.phaseQ == 2'd0)
                  || (mem[memAddr] != bus.wdata);
            end
         end
         ST_QLOAD: if (bus.wrStb) begin
            if (cur_ff.cnt == 3'd0 && !cur_ff.firstPage && !sameBlock) begin
               if (bus.wdata == fps_pkg::DATA_EXIT) begin
                  nxt_cur.st = ST_ARRAY;
                  nxt_cur.statusMode = 1'b0;
                  nxt_cur.status[fps_pkg::STAT_IDLE_BIT] = 1'b1;
                  nxt_cur.status[fps_pkg::STAT_BANK_BIT] = 1'b0;
               end
            end else begin
               if (cur_ff.cnt == 3'd0) begin
                  nxt_cur.buf0 = bus.wdata;
                  nxt_cur.status[fps_pkg::STAT_IDLE_BIT] = 1'b0;
                  if (cur_ff.firstPage) begin
                     nxt_cur.start = bus.addr;
                     nxt_cur.ptr = {bus.addr[21:2], 2'b00};
                  end else if (bus.addr == cur_ff.start) begin
                     nxt_cur.ptr = cur_ff.ptr + 22'd4;
                  end else begin
                     nxt_cur.ptr = {bus.addr[21:2], 2'b00};
                  end
                  nxt_cur.firstPage = 1'b0;
               end else if (cur_ff.cnt == 3'd1) begin
                  nxt_cur.buf1 = bus.wdata;
               end else if (cur_ff.cnt == 3'd2) begin
                  nxt_cur.buf2 = bus.wdata;
               end else begin
                  nxt_cur.buf3 = bus.wdata;
               end
               nxt_cur.cnt = cur_ff.cnt + 3'd1;
               if (cur_ff.cnt == 3'd3) begin
                  nxt_cur.cnt = 3'd0;
                  if (protectPage) begin
                     nxt_cur.st = ST_ARRAY;
                     nxt_cur.status[fps_pkg::STAT_PROT_ERR_BIT] = 1'b1;
                     nxt_cur.status[fps_pkg::STAT_IDLE_BIT] = 1'b1;
                  end else begin
                     nxt_cur.st = ST_ENGINE;
                     nxt_cur.streaming = 1'b1;
                     nxt_cur.timer = 8'(fps_pkg::PROG_CYCLES);
                     nxt_cur.status[fps_pkg::STAT_BANK_BIT] = 1'b1;
                  end
               end
            end
         end
         ST_ENGINE: begin
            // Writes are ignored here; the engine owns the bank.
            if (cur_ff.timer != 8'd0) begin
               nxt_cur.timer = cur_ff.timer - 8'd1;
            end else if (!cur_ff.streaming) begin
               nxt_cur.st = ST_ARRAY;
               nxt_cur.status[fps_pkg::STAT_IDLE_BIT] = 1'b1;
               nxt_cur.status[fps_pkg::STAT_BANK_BIT] = 1'b0;
            end else begin
               memAddr = {cur_ff.ptr[MW-1:2], cur_ff.cnt[1:0]};
               memData = pageWord;
               memWe = 1'b1;
               // Each cycle after the first verifies the word written on the cycle before.
               if (cur_ff.cnt != 3'd0
                     && mem[memAddr - MW'(1)] != prevWord) begin
                  nxt_cur.status[fps_pkg::STAT_PROG_ERR_BIT] = 1'b1;
               end
               nxt_cur.cnt = cur_ff.cnt + 3'd1;
               if (cur_ff.cnt == 3'd3) begin
                  nxt_cur.cnt = 3'd0;
                  nxt_cur.st = ST_QLOAD;
                  nxt_cur.status[fps_pkg::STAT_BANK_BIT] = 1'b0;
               end
            end
         end
         default: nxt_cur.st = ST_ARRAY;
      endcase
      nxt_cur.busy = nxt_cur.st != ST_ARRAY;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cur_ff <= '0;
         cur_ff.st <= ST_ARRAY;
         cur_ff.status <= fps_pkg::RESET_STATUS;
      end else begin
         cur_ff <= nxt_cur;
      end
      if (memWe) begin
         mem[memAddr] <= memData;
      end
   end
endmodule // fps_device

//--- logic/fps_pkg.sv
/*
 Shared constants for the factory program sequencer pair.
 Assumes one 10 MHz clock and a synchronous active-high reset.
*/
package fps_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int BLOCK_LSB = 15;
   localparam int BANK_LSB = 18;
   localparam logic [15:0] CMD_QUAD_FACTORY = 16'h0075;
   localparam logic [15:0] CMD_BANK_ERASE = 16'h0080;
   localparam logic [15:0] CMD_CONFIRM = 16'h00D0;
   localparam logic [15:0] CMD_DOUBLE_WORD = 16'h0035;
   localparam logic [15:0] CMD_QUAD_WORD = 16'h0056;
   localparam logic [15:0] CMD_STREAM = 16'h0030;
   localparam logic [15:0] DATA_EXIT = 16'hFFFF;
   localparam logic [15:0] RESET_STATUS = 16'h0080;
   localparam int STAT_IDLE_BIT = 7;
   localparam int STAT_PROG_ERR_BIT = 4;
   localparam int STAT_PROT_ERR_BIT = 1;
   localparam int STAT_BANK_BIT = 0;
   localparam int PROG_TIME_NS = 800;
   localparam int CLK_PERIOD_NS = 100;
   localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam logic [11:0] APB_CMD_OFF = 12'h000;
   localparam logic [11:0] APB_ADDR_OFF = 12'h004;
   localparam logic [11:0] APB_DATA_OFF = 12'h008;
   localparam logic [11:0] APB_STAT_OFF = 12'h00C;
   localparam logic [11:0] APB_RDATA_OFF = 12'h010;
endpackage

//--- logic/fps_if.sv
/*
 Flash bus between the controller and the sequencer.
 Assumes both ends share clk; a write is a one-cycle strobe.
*/
interface fps_if (input wire logic clk);
   logic wrStb;
   logic rdStb;
   logic [21:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic rdValid;
   logic programSupplyPin;
   modport dev (input wrStb, input rdStb, input addr, input wdata,
      input programSupplyPin, output rdata, output rdValid);
   modport host (output wrStb, output rdStb, output addr, output wdata,
      output programSupplyPin, input rdata, input rdValid);
endinterface

//--- logic/fps_host.sv
/*
 Host end: APB slave holding an order register and issuing flash bus
 writes and reads on command. Assumes software polls status itself.
*/
module fps_host (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash bus.
   fps_if.host bus
);
   typedef struct packed {
      logic [21:0] addr;
      logic [15:0] wdata;
      logic vppHigh;
      logic wrStb;
      logic rdStb;
      logic [15:0] rdata;
      logic rdDone;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } fpsh_s;
   fpsh_s cur_ff, nxt_cur;
   logic acc;

   assign acc = psel && !penable;
   assign bus.wrStb = cur_ff.wrStb;
   assign bus.rdStb = cur_ff.rdStb;
   assign bus.addr = cur_ff.addr;
   assign bus.wdata = cur_ff.wdata;
   assign bus.programSupplyPin = cur_ff.vppHigh;
   assign prdata = cur_ff.prdata;
   assign pready = cur_ff.pready;
   assign pslverr = cur_ff.pslverr;

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.wrStb = 1'b0;
      nxt_cur.rdStb = 1'b0;
      nxt_cur.pready = 1'b0;
      nxt_cur.pslverr = 1'b0;
      if (bus.rdValid) begin
         nxt_cur.rdata = bus.rdata;
         nxt_cur.rdDone = 1'b1;
      end
      if (acc) begin
         nxt_cur.pready = 1'b1;
         nxt_cur.prdata = 32'h0000_0000;
         unique case (paddr)
            fps_pkg::APB_CMD_OFF: if (pwrite) begin
               // Bit 0 issues a write, bit 1 a read, bit 2 sets supply.
               nxt_cur.wrStb = pwdata[0];
               nxt_cur.rdStb = pwdata[1];
               nxt_cur.vppHigh = pwdata[2];
               if (pwdata[1]) begin
                  nxt_cur.rdDone = 1'b0;
               end
            end
            fps_pkg::APB_ADDR_OFF: if (pwrite) begin
               nxt_cur.addr = pwdata[21:0];
            end else begin
               nxt_cur.prdata = {10'h000, cur_ff.addr};
            end
            fps_pkg::APB_DATA_OFF: if (pwrite) begin
               nxt_cur.wdata = pwdata[15:0];
            end else begin
               nxt_cur.prdata = {16'h0000, cur_ff.wdata};
            end
            fps_pkg::APB_STAT_OFF: if (!pwrite) begin
               nxt_cur.prdata = {29'h0, cur_ff.vppHigh, cur_ff.rdDone,
                  1'b0};
            end
            fps_pkg::APB_RDATA_OFF: if (!pwrite) begin
               nxt_cur.prdata = {16'h0000, cur_ff.rdata};
            end
            default: nxt_cur.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end
endmodule // fps_host

//--- dv/fps_checker_sva.sv
/*
 Bus-level checks of the quad-page factory program between both ends.
 Assumes it sits beside the interface and also sees the device's busy.
*/
module fps_checker_sva #(
   parameter int PROT_BLOCK = 1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Flash bus.
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [21:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic rdValid,
   input wire logic programSupplyPin,
   // Device observation.
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic qAct_ff;
   logic started_ff;
   logic [1:0] wCnt_ff;
   logic [7:0] eng_ff;
   logic [6:0] blk_ff;
   logic sameBlk;
   logic isExit;
   logic inEng;
   assign sameBlk = addr[21:15] == blk_ff;
   assign isExit = qAct_ff && started_ff && wrStb && wCnt_ff == 2'd0
      && wdata == fps_pkg::DATA_EXIT && !sameBlk;
   assign inEng = eng_ff >= 8'd3 && eng_ff <= 8'(fps_pkg::PROG_CYCLES);
   // Follows the command as the bus shows it; eng_ff counts engine time.
   always_ff @(posedge clk) begin
      if (srst) begin
         qAct_ff <= 1'b0;
         started_ff <= 1'b0;
         wCnt_ff <= 2'd0;
         eng_ff <= 8'd0;
         blk_ff <= 7'd0;
      end else if (wrStb && !qAct_ff) begin
         qAct_ff <= wdata == fps_pkg::CMD_QUAD_FACTORY && programSupplyPin;
         started_ff <= 1'b0;
         wCnt_ff <= 2'd0;
         eng_ff <= 8'd0;
      end else if (isExit) begin
         qAct_ff <= 1'b0;
      end else if (wrStb) begin
         if (!started_ff) begin
            blk_ff <= addr[21:15];
            qAct_ff <= addr[21:15] != 7'(PROT_BLOCK);
         end
         started_ff <= 1'b1;
         wCnt_ff <= wCnt_ff + 2'd1;
         eng_ff <= wCnt_ff == 2'd3 ? 8'd1 : 8'd0;
      end else if (eng_ff != 8'd0 && eng_ff != 8'hFF) begin
         eng_ff <= eng_ff + 8'd1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence setupWr_s;
      wrStb && !qAct_ff && wdata == fps_pkg::CMD_QUAD_FACTORY;
   endsequence
   sequence ffffData_s;
      qAct_ff && started_ff && wrStb && wdata == fps_pkg::DATA_EXIT
         && (wCnt_ff != 2'd0 || sameBlk);
   endsequence
   rd_answer_a: assert property (rdStb |=> rdValid)
      else $error("Read strobe got no answer.");
   setup_enter_a: assert property (
      setupWr_s ##0 programSupplyPin |=> busy)
      else $error("Setup write did not leave array mode.");
   no_supply_a: assert property (
      setupWr_s ##0 !programSupplyPin && !busy |=> !busy [*2])
      else $error("Setup without supply was not ignored.");
   status_only_a: assert property (
      qAct_ff && rdValid |-> rdata[15:8] == 8'h00)
      else $error("Read during the command did not give status.");
   engine_flags_a: assert property (
      qAct_ff && inEng && rdValid |-> !rdata[7] && rdata[0])
      else $error("Flags wrong while the engine runs.");
   engine_end_a: assert property (
      qAct_ff && rdValid && eng_ff > 8'(fps_pkg::PROG_CYCLES + 8)
      |-> rdata[0] == 1'b0
      && rdata[4] == 1'b0)
      else $error("Engine phase did not end cleanly.");
   load_hold_a: assert property (ffffData_s |=> busy [*2])
      else $error("All-ones data word ended the command.");
   exit_a: assert property (isExit |-> ##[1:4] !busy)
      else $error("Exit write did not return to array mode.");
endmodule // fps_checker_sva

//--- dv/tb_factory_program_sequencer.sv
/*
 Self-checking bench joining the host and device ends of the sequencer.
 Assumes the host order map of the package and a 10 MHz clock.
*/
`define CHK(nm, ex, got) begin \
   nChecks++; \
   if ((got) !== (ex)) begin \
      errorCnt++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
   end \
end
module tb_factory_program_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic busy;
   logic sup = 1'b0;
   logic [15:0] s;
   int errorCnt = 0;
   int nChecks = 0;
   always #50 clk = ~clk;
   fps_if fps_if_i (.clk(clk));
   fps_device #(.MEM_WORDS(256), .PROT_BLOCK(1)) fps_device_i (.clk(clk),
      .srst(srst), .bus(fps_if_i.dev), .busy(busy));
   fps_host fps_host_i (.clk(clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus(fps_if_i.host));
   fps_checker_sva #(.PROT_BLOCK(1)) fps_checker_sva_i (.clk(clk),
      .srst(srst), .wrStb(fps_if_i.wrStb), .rdStb(fps_if_i.rdStb),
      .addr(fps_if_i.addr), .wdata(fps_if_i.wdata),
      .rdata(fps_if_i.rdata), .rdValid(fps_if_i.rdValid),
      .programSupplyPin(fps_if_i.programSupplyPin), .busy(busy));
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 20) begin
         k++;
         @(posedge clk);
      end
      `CHK("pready", 1'b1, pready)
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic fw(input logic [21:0] a, input logic [15:0] d);
      wr(fps_pkg::APB_ADDR_OFF, {10'h0, a});
      wr(fps_pkg::APB_DATA_OFF, {16'h0, d});
      wr(fps_pkg::APB_CMD_OFF, {29'h0, sup, 2'b01});
   endtask
   task automatic rs(output logic [15:0] d);
      logic [31:0] r;
      logic e;
      int k;
      wr(fps_pkg::APB_CMD_OFF, {29'h0, sup, 2'b10});
      k = 0;
      r = 32'h0;
      while (r[1] !== 1'b1 && k < 10) begin
         apb(1'b0, fps_pkg::APB_STAT_OFF, 32'h0, r, e);
         k++;
      end
      `CHK("read done", 1'b1, r[1])
      apb(1'b0, fps_pkg::APB_RDATA_OFF, 32'h0, r, e);
      d = r[15:0];
   endtask
   task automatic fr(input logic [21:0] a, output logic [15:0] d);
      wr(fps_pkg::APB_ADDR_OFF, {10'h0, a});
      rs(d);
   endtask
   task automatic waitBit(input int b, input logic v);
      int k;
      k = 0;
      rs(s);
      while (s[b] !== v && k < 40) begin
         rs(s);
         k++;
      end
      `CHK("flag wait", v, s[b])
   endtask
   task automatic page(input logic [21:0] a, input logic [15:0] base,
      input int ff, input logic first);
      for (int i = 0; i < 4; i++) begin
         fw(i == 0 ? a : (i == 3 ? 22'h000000 : 22'h3FFFFF),
            i == ff ? 16'hFFFF : base + 16'(i));
         if (i == 0) begin
            fr(22'h300000, s);
         end else begin
            rs(s);
         end
         if (i == 0 && first) `CHK("accepted", 1'b0, s[7])
      end
      `CHK("engine flags", 2'b01, {s[7], s[0]})
      waitBit(0, 1'b0);
      `CHK("page errors", 2'b00, {s[4], s[1]})
   endtask
   task automatic run(input logic [15:0] c0, input logic [15:0] c1,
      input int n, input logic [21:0] a);
      fw(a, c0);
      if (c1 !== 16'h0000) fw(a, c1);
      for (int i = 0; i < n; i++) fw(a + 22'(i), 16'h1230 + 16'(i));
      waitBit(7, 1'b1);
      `CHK("error bits", 2'b00, {s[4], s[1]})
   endtask
   task automatic tBasics();
      logic [31:0] r;
      logic e;
      apb(1'b0, fps_pkg::APB_RDATA_OFF, 32'h0, r, e);
      `CHK("rdata reset", 32'h0, r)
      apb(1'b0, 12'h020, 32'h0, r, e);
      `CHK("unmapped", 1'b1, e)
      wr(fps_pkg::APB_ADDR_OFF, 32'h0012_3456);
      apb(1'b0, fps_pkg::APB_ADDR_OFF, 32'h0, r, e);
      `CHK("addr readback", 32'h0012_3456, r)
      wr(fps_pkg::APB_DATA_OFF, 32'h0000_BEEF);
      apb(1'b0, fps_pkg::APB_DATA_OFF, 32'h0, r, e);
      `CHK("data readback", 32'h0000_BEEF, r)
   endtask
   task automatic tNoSupply();
      sup = 1'b0;
      wr(fps_pkg::APB_CMD_OFF, 32'h0);
      fw(22'h010000, fps_pkg::CMD_QUAD_FACTORY);
      repeat (3) @(negedge clk);
      `CHK("no supply busy", 1'b0, busy)
   endtask
   task automatic tQuadPages();
      logic [21:0] ra [0:6];
      logic [15:0] rd [0:6];
      logic [15:0] v;
      ra = '{22'h010010, 22'h010012, 22'h010013, 22'h010014, 22'h010017,
         22'h010020, 22'h010023};
      rd = '{16'hA000, 16'hFFFF, 16'hA003, 16'hB000, 16'hB003, 16'hFFFF,
         16'hC003};
      sup = 1'b1;
      wr(fps_pkg::APB_CMD_OFF, 32'h4);
      fw(22'h010000, fps_pkg::CMD_QUAD_FACTORY);
      repeat (2) @(negedge clk);
      `CHK("setup busy", 1'b1, busy)
      page(22'h010010, 16'hA000, 2, 1'b1);
      page(22'h010010, 16'hB000, 4, 1'b0);
      page(22'h010020, 16'hC000, 0, 1'b0);
      fw(22'h000000, fps_pkg::DATA_EXIT);
      repeat (4) @(negedge clk);
      `CHK("exit busy", 1'b0, busy)
      for (int i = 0; i < 7; i++) begin
         fr(ra[i], v);
         `CHK("array word", rd[i], v)
      end
   endtask
   task automatic tOtherCmds();
      run(fps_pkg::CMD_BANK_ERASE, fps_pkg::CMD_CONFIRM, 0, 22'h040000);
      run(fps_pkg::CMD_DOUBLE_WORD, 16'h0000, 2, 22'h040040);
      run(fps_pkg::CMD_QUAD_WORD, 16'h0000, 4, 22'h040044);
      fw(22'h040080, fps_pkg::CMD_STREAM);
      fw(22'h040081, fps_pkg::CMD_CONFIRM);
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 3; i++) begin
            fw(22'h040080, 16'h5A00 + 16'(i));
            waitBit(0, 1'b0);
         end
         fw(22'h000000, fps_pkg::DATA_EXIT);
         waitBit(0, 1'b0);
      end
      waitBit(7, 1'b1);
      `CHK("stream errors", 2'b00, {s[4], s[1]})
   endtask
   task automatic tProtected();
      fw(22'h008000, fps_pkg::CMD_QUAD_FACTORY);
      for (int i = 0; i < 4; i++) fw(22'h008004 + 22'(i), 16'h7700);
      waitBit(7, 1'b1);
      `CHK("protect error", 1'b1, s[1])
   endtask
   task automatic endOfTest();
      $display("Checks %0d, mismatches %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      tBasics();
      tNoSupply();
      tQuadPages();
      tOtherCmds();
      tProtected();
      endOfTest();
   end
   // The whole sequence needs under a thousand cycles; this allows 20000.
   initial begin
      #2000000;
      errorCnt++;
      endOfTest();
   end
endmodule // tb_factory_program_sequencer
